/* pkg/power_reset_pkg.sv */
// constants, offsets and types shared by the power register block
package power_reset_pkg;

  // ----------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------
  localparam logic [11:0] OFF_INT_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFF_INT_DISABLE = 12'h308;
  localparam logic [11:0] OFF_RESET_CAUSE = 12'h400;
  localparam logic [11:0] OFF_SYSTEM_OFF = 12'h500;
  localparam logic [11:0] OFF_COMP_CONFIG = 12'h510;
  localparam logic [11:0] OFF_RETAINED = 12'h51C;
  localparam logic [11:0] OFF_INT_STATUS = 12'h600;
  localparam logic [11:0] OFF_INT_CLEAR = 12'h604;

  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int EV_SUPPLY_WARN = 0;
  localparam int EV_SLEEP_ENTER = 1;
  localparam int EV_SLEEP_EXIT = 2;
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_WATCHDOG = 1;
  localparam int CAUSE_SOFTWARE = 2;
  localparam int CAUSE_PROCESSOR_CAUSE_A = 3;
  localparam int CAUSE_OFF_GPIO = 4;
  localparam int CAUSE_OFF_DEBUG = 5;
  localparam int SYSOFF_ENTER_BIT = 0;
  localparam int COMP_ENABLE_BIT = 0;
  localparam int COMP_THRESH_LSB = 1;
  localparam int COMP_THRESH_MSB = 4;

  // ----------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------
  localparam logic [2:0] INT_ENABLE_RESET = 3'h0;
  localparam logic [2:0] INT_STATUS_RESET = 3'h0;
  localparam logic [5:0] RESET_CAUSE_RESET = 6'h00;
  localparam logic [7:0] RETAINED_RESET = 8'h00;
  localparam logic [3:0] COMP_THRESH_RESET = 4'h0;

  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic {MODE_ON, MODE_OFF} power_mode_e;

endpackage

/* pkg/power_retain_if.sv */
// carrier between the register block and its retained store
`timescale 1ns/1ps
interface power_retain_if;
  logic [5:0] set_causes;   // cause pulses from reset sources
  logic [5:0] clear_causes; // write-one-to-clear mask
  logic [5:0] causes;       // stored cause flags
  logic byte_we;            // retained byte write strobe
  logic [7:0] byte_wdata;   // retained byte write value
  logic [7:0] byte_q;       // stored retained byte

  // register block side
  modport regs (output set_causes, clear_causes, byte_we, byte_wdata,
                input causes, byte_q);
  // storage side
  modport store (input set_causes, clear_causes, byte_we, byte_wdata,
                 output causes, byte_q);
endinterface

/* rtl/power_reset_status_regs.sv */
// power-management register block: interrupts, reset causes, system off, comparator
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Behaviour
// RQ1 - one disables warning interrupt; read shows enable
// RQ2 - one disables sleep-entry interrupt; zero ignored
// RQ3 - one disables sleep-exit interrupt; read shows enable
// RQ4 - reset causes accumulate until software clears
// RQ5 - writing one clears a cause flag
// RQ6 - no flag means power-on or brownout
// RQ7 - pin reset sets pin cause flag
// RQ8 - watchdog reset sets watchdog cause flag
// RQ9 - soft reset request sets software flag
// RQ10 - processor processor_cause_a sets processor_cause_a cause flag
// RQ11 - wake by input detect sets flag
// RQ12 - wake by debug entry sets flag
// RQ13 - writing one enters system off
// RQ14 - enable bit switches comparator on/off
// RQ15 - threshold code 4..15 selects 1.7..2.8 V
// RQ16 - retained byte survives ordinary resets
// RQ17 - enabled comparator falling supply raises warning
// RQ18 - cause flags live in reset-proof storage
// ------------------------------------------------------------
module power_reset_status_regs #(
  parameter int ADDR_W = 12 // register address width
) (
  // clock and resets
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_por,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // processor sleep events
  input wire logic i_sleep_enter,
  input wire logic i_sleep_exit,
  // comparator result for the selected threshold
  input wire logic i_supply_below,
  // reset and wake sources
  input wire logic i_pin_reset,
  input wire logic i_watchdog_reset,
  input wire logic i_soft_reset_req,
  input wire logic i_processor_cause_a_reset,
  input wire logic i_off_wake_gpio,
  input wire logic i_off_wake_debug,
  // power control
  output logic o_system_off,
  output logic o_comparator_enable,
  output logic [3:0] o_comparator_threshold,
  output logic [7:0] o_retained_byte,
  // interrupt
  output logic o_irq
);

  // ----------------------------------------------------------
  // state of the block
  // ----------------------------------------------------------
  typedef struct packed {
    power_reset_pkg::power_mode_e mode; // system on or off
    logic [2:0] int_enable;  // per-event interrupt enable
    logic [2:0] status;      // sticky event flags
    logic comp_enable;       // comparator on
    logic [3:0] threshold;   // comparator threshold code
    logic below_seen;        // last qualified comparator level
    logic irq;               // registered interrupt level
    logic [31:0] rdata;      // read answer register
  } state_s;

  state_s st;      // registered state
  state_s next_st; // next state

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------

  // address match against a byte offset
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [11:0] off);
    hit = (addr == ADDR_W'(off));
  endfunction

  // write strobe qualified by address
  function automatic logic wr_hit(input logic wr,
                                  input logic [ADDR_W-1:0] addr,
                                  input logic [11:0] off);
    wr_hit = wr && hit(addr, off);
  endfunction

  // ----------------------------------------------------------
  // retained store
  // ----------------------------------------------------------
  power_retain_if rif ();

  retention_store u_store (
    .i_mclk (i_mclk),
    .i_por (i_por),
    .rif (rif)
  );

  // cause pulses gathered into the stored layout
  logic [5:0] cause_set;

  // collect reset and wake sources
  always_comb begin
    cause_set = 6'h00;
    // RQ7 pin reset flag
    cause_set[power_reset_pkg::CAUSE_PIN] = i_pin_reset;
    // RQ8 watchdog reset flag
    cause_set[power_reset_pkg::CAUSE_WATCHDOG] = i_watchdog_reset;
    // RQ9 soft request flag
    cause_set[power_reset_pkg::CAUSE_SOFTWARE] = i_soft_reset_req;
    // RQ10 processor_cause_a reset flag
    cause_set[power_reset_pkg::CAUSE_PROCESSOR_CAUSE_A] = i_processor_cause_a_reset;
    // RQ11 wake by detect
    cause_set[power_reset_pkg::CAUSE_OFF_GPIO] = i_off_wake_gpio;
    // RQ12 wake by debug
    cause_set[power_reset_pkg::CAUSE_OFF_DEBUG] = i_off_wake_debug;
  end

  // RQ6 no source, no flag
  assign rif.set_causes = cause_set;

  // RQ5 clear mask from writes
  assign rif.clear_causes =
    (!i_reset && wr_hit(i_wr, i_addr, power_reset_pkg::OFF_RESET_CAUSE))
    ? i_wdata[5:0] : 6'h00;

  // retained byte write, blocked while in reset
  assign rif.byte_we =
    !i_reset && wr_hit(i_wr, i_addr, power_reset_pkg::OFF_RETAINED);
  assign rif.byte_wdata = i_wdata[7:0];

  // ----------------------------------------------------------
  // event detection
  // ----------------------------------------------------------
  logic below_now; // comparator level seen while enabled
  logic [2:0] ev;  // one-cycle event pulses

  // events of this cycle
  always_comb begin
    below_now = st.comp_enable && i_supply_below;
    ev = 3'h0;
    // RQ17 warning on falling supply
    ev[power_reset_pkg::EV_SUPPLY_WARN] = below_now && !st.below_seen;
    ev[power_reset_pkg::EV_SLEEP_ENTER] = i_sleep_enter;
    ev[power_reset_pkg::EV_SLEEP_EXIT] = i_sleep_exit;
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.below_seen = below_now;

    // enable set register
    if (wr_hit(i_wr, i_addr, power_reset_pkg::OFF_INT_ENABLE_SET)) begin
      next_st.int_enable = st.int_enable | i_wdata[2:0];
    end

    // RQ1 disable warning interrupt
    // RQ2 disable sleep entry
    // RQ3 disable sleep exit
    if (wr_hit(i_wr, i_addr, power_reset_pkg::OFF_INT_DISABLE)) begin
      next_st.int_enable = st.int_enable & ~i_wdata[2:0];
    end

    // sticky status: new events win over the clear
    if (wr_hit(i_wr, i_addr, power_reset_pkg::OFF_INT_CLEAR)) begin
      next_st.status = (st.status & ~i_wdata[2:0]) | ev;
    end else begin
      next_st.status = st.status | ev;
    end

    // RQ13 enter system off
    if (wr_hit(i_wr, i_addr, power_reset_pkg::OFF_SYSTEM_OFF) &&
        i_wdata[power_reset_pkg::SYSOFF_ENTER_BIT]) begin
      next_st.mode = power_reset_pkg::MODE_OFF;
    end

    // RQ14 comparator enable bit
    // RQ15 threshold code stored
    if (wr_hit(i_wr, i_addr, power_reset_pkg::OFF_COMP_CONFIG)) begin
      next_st.comp_enable = i_wdata[power_reset_pkg::COMP_ENABLE_BIT];
      next_st.threshold =
        i_wdata[power_reset_pkg::COMP_THRESH_MSB:power_reset_pkg::COMP_THRESH_LSB];
    end

    // RQ17 enabled status drives interrupt
    next_st.irq = |(next_st.status & next_st.int_enable);

    // read answer, valid only the cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        // enable state seen through both enable registers
        ADDR_W'(power_reset_pkg::OFF_INT_ENABLE_SET): begin
          next_st.rdata[2:0] = st.int_enable;
        end
        // RQ1 read shows enable state
        ADDR_W'(power_reset_pkg::OFF_INT_DISABLE): begin
          next_st.rdata[2:0] = st.int_enable;
        end
        // RQ4 accumulated causes
        ADDR_W'(power_reset_pkg::OFF_RESET_CAUSE): begin
          next_st.rdata[5:0] = rif.causes;
        end
        // comparator configuration readback
        ADDR_W'(power_reset_pkg::OFF_COMP_CONFIG): begin
          next_st.rdata[power_reset_pkg::COMP_ENABLE_BIT] = st.comp_enable;
          next_st.rdata[power_reset_pkg::COMP_THRESH_MSB:
                        power_reset_pkg::COMP_THRESH_LSB] = st.threshold;
        end
        // RQ16 retained byte
        ADDR_W'(power_reset_pkg::OFF_RETAINED): begin
          next_st.rdata[7:0] = rif.byte_q;
        end
        // sticky event flags
        ADDR_W'(power_reset_pkg::OFF_INT_STATUS): begin
          next_st.rdata[2:0] = st.status;
        end
        // write-only and unmapped read zero
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------

  // system reset returns all but the retained store
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st.mode <= power_reset_pkg::MODE_ON;
      st.int_enable <= power_reset_pkg::INT_ENABLE_RESET;
      st.status <= power_reset_pkg::INT_STATUS_RESET;
      st.comp_enable <= 1'b0;
      st.threshold <= power_reset_pkg::COMP_THRESH_RESET;
      st.below_seen <= 1'b0;
      st.irq <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------

  // mode decode, held in off until reset
  always_comb begin
    case (st.mode)
      power_reset_pkg::MODE_OFF: o_system_off = 1'b1;
      power_reset_pkg::MODE_ON: o_system_off = 1'b0;
      default: o_system_off = 1'b0;
    endcase
  end

  // flop outputs
  assign o_rdata = st.rdata;
  assign o_comparator_enable = st.comp_enable;
  assign o_comparator_threshold = st.threshold;
  assign o_retained_byte = rif.byte_q;
  assign o_irq = st.irq;

endmodule

/* rtl/retention_store.sv */
// storage that survives the system reset: cause flags and retained byte
`timescale 1ns/1ps
module retention_store (
  // clock and power-on reset
  input wire logic i_mclk,
  input wire logic i_por,
  // register block link
  power_retain_if.store rif
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    logic [5:0] causes; // accumulated reset causes
    logic [7:0] gp;     // general retained byte
  } keep_s;

  keep_s st;      // registered copy
  keep_s next_st; // next value

  // next value: causes accumulate, set beats clear
  always_comb begin
    next_st = st;
    // RQ4 cumulative sticky flags
    // RQ5 ones clear, zeros keep
    next_st.causes = (st.causes & ~rif.clear_causes) | rif.set_causes;
    // RQ16 byte kept across resets
    if (rif.byte_we) begin
      next_st.gp = rif.byte_wdata;
    end
  end

  // RQ18 only power-on clears this
  always_ff @(posedge i_mclk or posedge i_por) begin
    if (i_por) begin
      st <= {power_reset_pkg::RESET_CAUSE_RESET, power_reset_pkg::RETAINED_RESET};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the store
  assign rif.causes = st.causes;
  assign rif.byte_q = st.gp;

endmodule

/* sim/power_reset_chk.sv */
// port-level checks for the power register block
`timescale 1ns/1ps
module power_reset_chk #(
  parameter int ADDR_W = 12
) (
  // clock, resets, register port
  input wire logic i_mclk, i_reset, i_por, i_wr, i_rd,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata, o_rdata,
  // events and sources
  input wire logic i_sleep_enter, i_sleep_exit, i_supply_below, i_pin_reset,
  input wire logic i_watchdog_reset, i_soft_reset_req, i_processor_cause_a_reset,
  input wire logic i_off_wake_gpio, i_off_wake_debug,
  // outputs
  input wire logic o_system_off, o_comparator_enable, o_irq,
  input wire logic [3:0] o_comparator_threshold,
  input wire logic [7:0] o_retained_byte
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  sysoff_enter_a: assert property (i_wr && i_addr == 12'h500 && i_wdata[0] |=> o_system_off)
    else $error("system off not entered");
  sysoff_hold_a: assert property (o_system_off |=> o_system_off)
    else $error("system off dropped without reset");
  comp_write_a: assert property (i_wr && i_addr == 12'h510 |=>
    {o_comparator_threshold, o_comparator_enable} == $past(i_wdata[4:0]))
    else $error("comparator config not taken");
  comp_hold_a: assert property (!(i_wr && i_addr == 12'h510) |=>
    $stable({o_comparator_threshold, o_comparator_enable}))
    else $error("comparator config changed without write");
  retain_write_a: assert property (i_wr && i_addr == 12'h51C |=>
    o_retained_byte == $past(i_wdata[7:0]))
    else $error("retained byte not written");
  irq_disable_a: assert property (i_wr && i_addr == 12'h308 && i_wdata[2:0] == 3'h7
    ##1 !(i_wr && i_addr == 12'h304) |=> !o_irq)
    else $error("interrupt stays high after full disable");
  wo_read_a: assert property (i_rd && i_addr == 12'h500 |=> o_rdata == 32'h0)
    else $error("write-only register read not zero");
endmodule

/* sim/testbench.sv */
// self-checking bench for the power register block
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic i_mclk, i_reset, i_por, i_wr, i_rd, i_sleep_enter, i_sleep_exit, i_supply_below;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, seed, tmp;
  logic [5:0] src; // reset and wake sources, one bit per cause
  logic [5:0] causes; // expected cause flags
  logic [7:0] keep; // expected retained byte
  logic o_system_off, o_comparator_enable, o_irq;
  logic [3:0] o_comparator_threshold;
  logic [7:0] o_retained_byte;
  int errors, checks_done;

  power_reset_status_regs #(.ADDR_W(12)) i_dut (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_por(i_por), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_enter(i_sleep_enter),
    .i_sleep_exit(i_sleep_exit), .i_supply_below(i_supply_below), .i_pin_reset(src[0]),
    .i_watchdog_reset(src[1]), .i_soft_reset_req(src[2]), .i_processor_cause_a_reset(src[3]),
    .i_off_wake_gpio(src[4]), .i_off_wake_debug(src[5]), .o_system_off(o_system_off),
    .o_comparator_enable(o_comparator_enable),
    .o_comparator_threshold(o_comparator_threshold),
    .o_retained_byte(o_retained_byte), .o_irq(o_irq));

  // 100 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // comparator config keeps only enable and threshold
  function automatic logic [31:0] comp_exp(input logic [31:0] d);
    return d & 32'h0000001F;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask

  // read, data stands only in the following cycle
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    cyc(1);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
    cyc(1);
  endtask

  task automatic irqc(input logic exp);
    #1 chk({31'h0, o_irq}, {31'h0, exp});
    cyc(1);
  endtask

  // bit0 supply level, bit1 sleep entry pulse, bit2 sleep exit pulse
  task automatic evt(input logic [2:0] e);
    i_supply_below <= e[0];
    i_sleep_enter <= e[1];
    i_sleep_exit <= e[2];
    cyc(1);
    i_sleep_enter <= 1'b0;
    i_sleep_exit <= 1'b0;
    cyc(2);
  endtask

  // system reset with cause pulse; p adds power-on reset
  task automatic sys_reset(input logic [5:0] c, input logic p);
    i_reset <= 1'b1;
    i_por <= p;
    src <= c;
    cyc(1);
    src <= 6'h00;
    cyc(5);
    i_reset <= 1'b0;
    i_por <= 1'b0;
    cyc(1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {i_reset, i_por, i_wr, i_rd, i_sleep_enter, i_sleep_exit, i_supply_below} = 7'h00;
    {i_addr, i_wdata, src, causes} = 56'h0;
    errors = 0;
    checks_done = 0;
    seed = 32'hD66643DD;
    sys_reset(6'h00, 1'b1);
    rdc(12'h308, 32'h0);
    rdc(12'h400, 32'h0);
    rdc(12'h510, 32'h0);
    rdc(12'h500, 32'h0);
    rdc(12'h7FC, 32'h0);
    // enable all, then disable one at a time
    wr(12'h304, 32'h7);
    rdc(12'h308, 32'h7);
    evt(3'h2);
    irqc(1'b1);
    wr(12'h308, 32'h0);
    rdc(12'h308, 32'h7);
    wr(12'h308, 32'h2);
    irqc(1'b0);
    rdc(12'h308, 32'h5);
    wr(12'h604, 32'h7);
    evt(3'h4);
    irqc(1'b1);
    wr(12'h308, 32'h4);
    irqc(1'b0);
    wr(12'h604, 32'h7);
    // warning from comparator at lowest threshold
    wr(12'h510, 32'h9);
    evt(3'h1);
    irqc(1'b1);
    rdc(12'h600, 32'h1);
    wr(12'h308, 32'h7);
    cyc(1);
    irqc(1'b0);
    rdc(12'h308, 32'h0);
    // threshold codes 4..15 with random upper bits
    for (int c = 4; c <= 15; c++) begin
      seed = xs(seed);
      tmp = {seed[31:5], c[3:0], seed[0]};
      wr(12'h510, tmp);
      chk({27'h0, o_comparator_threshold, o_comparator_enable}, comp_exp(tmp));
      rdc(12'h510, comp_exp(tmp));
    end
    // random retained bytes
    for (int n = 0; n < 16; n++) begin
      seed = xs(seed);
      keep = seed[7:0];
      wr(12'h51C, seed);
      chk({24'h0, o_retained_byte}, {24'h0, keep});
      rdc(12'h51C, {24'h0, keep});
    end
    // each reset source in turn, flags accumulate
    for (int k = 0; k < 6; k++) begin
      causes[k] = 1'b1;
      sys_reset(6'h01 << k, 1'b0);
      rdc(12'h400, {26'h0, causes});
    end
    rdc(12'h51C, {24'h0, keep});
    wr(12'h400, 32'h0);
    rdc(12'h400, {26'h0, causes});
    seed = xs(seed);
    wr(12'h400, seed);
    causes = causes & ~seed[5:0];
    rdc(12'h400, {26'h0, causes});
    // system off entry and exit by reset
    wr(12'h500, 32'h1);
    chk({31'h0, o_system_off}, 32'h1);
    rdc(12'h500, 32'h0);
    sys_reset(6'h00, 1'b0);
    chk({31'h0, o_system_off}, 32'h0);
    sys_reset(6'h00, 1'b1);
    rdc(12'h400, 32'h0);
    report_and_stop();
  end
endmodule

bind power_reset_status_regs power_reset_chk #(.ADDR_W(ADDR_W)) u_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_por(i_por), .i_wr(i_wr), .i_rd(i_rd),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_sleep_enter(i_sleep_enter),
  .i_sleep_exit(i_sleep_exit), .i_supply_below(i_supply_below), .i_pin_reset(i_pin_reset),
  .i_watchdog_reset(i_watchdog_reset), .i_soft_reset_req(i_soft_reset_req),
  .i_processor_cause_a_reset(i_processor_cause_a_reset), .i_off_wake_gpio(i_off_wake_gpio),
  .i_off_wake_debug(i_off_wake_debug), .o_system_off(o_system_off),
  .o_comparator_enable(o_comparator_enable), .o_irq(o_irq),
  .o_comparator_threshold(o_comparator_threshold), .o_retained_byte(o_retained_byte));
